// ===== hw/afct_top.sv
// afct_top: automatic flow control trigger with its register slave
// What this block does
// - duration field sets back-pressure period; field ignored in full duplex
// - 100 Mbps codes give 5,10,15,25,50,100 then 150..600 us in 50 us steps
// - 10 Mbps adds 2.2 us to every duration code
// - multicast trigger bit plus level reached jams on multicast frames, half duplex
// - broadcast trigger bit plus level reached jams on broadcast frames, half duplex
// - address trigger bit plus level reached jams on frames for our address
// - any-frame bit: jam in half duplex, pause frames in full duplex
// - half duplex any-frame triggers at next valid preamble, no address decode
// - full duplex any-frame requests one pause frame when level is reached
// - any-frame bit overrides the multicast, broadcast and address bits
// - trigger condition is receive FIFO reaching its programmed high level
// - each triggering frame in half duplex is jammed for the set period
// - no pause frame and no back pressure while transmitter disabled
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module afct_top #(
  parameter afct_pkg::afct_tab_t BP_CYC_100 = afct_pkg::BP_CYC_100_DEF,
  parameter afct_pkg::afct_cnt_t BP_CYC_EXTRA_10 = afct_pkg::BP_CYC_EXTRA_10_DEF
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [afct_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [afct_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [afct_pkg::AXI_DW/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [afct_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [afct_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fifo_level_reached,
  input wire logic full_duplex,
  input wire logic speed_10mbps,
  input wire logic tx_enable,
  input wire logic rx_preamble_valid,
  input wire logic rx_da_valid,
  input wire logic rx_da_multicast,
  input wire logic rx_da_broadcast,
  input wire logic rx_da_addr_match,
  output logic backpressure,
  output logic pause_request
);
  typedef struct packed {
    logic aw_got;
    logic [afct_pkg::AXI_AW-1:0] awaddr;
    logic w_got;
    logic [afct_pkg::CFG_W-1:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [afct_pkg::AXI_DW-1:0] rdata;
    logic [afct_pkg::CFG_W-1:0] cfg;
    logic pause_sent;
    logic pause_req;
  } afct_st_t;

  afct_st_t st_ff;
  afct_st_t nxt_st;
  afct_link_if lnk ();

  logic aw_now;
  logic w_now;
  logic [afct_pkg::AXI_AW-1:0] wr_addr;
  logic [afct_pkg::CFG_W-1:0] wr_data;
  logic wr_strb0;
  logic do_write;
  logic [afct_pkg::STAT_W-1:0] stat;
  logic [afct_pkg::DUR_W-1:0] dur_code;
  logic trig_any;
  logic half_ok;
  afct_pkg::afct_cnt_t dur_cyc;

  // ****************************************
  // configuration fields
  // ****************************************
  assign dur_code = st_ff.cfg[afct_pkg::DUR_LSB +: afct_pkg::DUR_W];
  assign trig_any = st_ff.cfg[afct_pkg::TRIG_ANY_BIT];
  assign half_ok = !full_duplex && tx_enable;

  always_comb begin
    dur_cyc = BP_CYC_100[dur_code];
    if (speed_10mbps) begin
      dur_cyc = afct_pkg::afct_cnt_t'(BP_CYC_100[dur_code] + BP_CYC_EXTRA_10);
    end
  end

  // ****************************************
  // qualifier and timer
  // ****************************************
  assign lnk.preamble = rx_preamble_valid;
  assign lnk.da_valid = rx_da_valid;
  assign lnk.is_mc = rx_da_multicast;
  assign lnk.is_bc = rx_da_broadcast;
  assign lnk.addr_match = rx_da_addr_match;
  assign lnk.trig = st_ff.cfg[afct_pkg::TRIG_W-1:0];
  assign lnk.armed = half_ok && fifo_level_reached;
  assign lnk.start = lnk.hit;
  assign lnk.abort = !half_ok;
  assign lnk.load = dur_cyc;

  afct_qual u_qual (
    .sys_clk(sys_clk),
    .srst(srst),
    .lnk(lnk)
  );

  afct_timer u_timer (
    .sys_clk(sys_clk),
    .srst(srst),
    .lnk(lnk)
  );

  assign backpressure = lnk.busy && half_ok;

  // ****************************************
  // status word
  // ****************************************
  always_comb begin
    stat = '0;
    stat[afct_pkg::STAT_BP_BIT] = backpressure;
    stat[afct_pkg::STAT_LVL_BIT] = fifo_level_reached;
    stat[afct_pkg::STAT_PSENT_BIT] = st_ff.pause_sent;
    stat[afct_pkg::STAT_FD_BIT] = full_duplex;
    stat[afct_pkg::STAT_SPD10_BIT] = speed_10mbps;
  end

  // ****************************************
  // bus handshakes
  // ****************************************
  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rdata = st_ff.rdata;
  assign pause_request = st_ff.pause_req && tx_enable;

  assign aw_now = st_ff.aw_got || (s_axi_awvalid && s_axi_awready);
  assign w_now = st_ff.w_got || (s_axi_wvalid && s_axi_wready);
  assign do_write = aw_now && w_now;
  assign wr_addr = st_ff.aw_got ? st_ff.awaddr : s_axi_awaddr;
  assign wr_data = st_ff.w_got ? st_ff.wdata : s_axi_wdata[afct_pkg::CFG_W-1:0];
  assign wr_strb0 = st_ff.w_got ? st_ff.wstrb0 : s_axi_wstrb[0];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pause_req = 1'b0;
    // write channel
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata[afct_pkg::CFG_W-1:0];
      nxt_st.wstrb0 = s_axi_wstrb[0];
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (do_write) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = afct_pkg::RESP_OKAY;
      if (wr_addr[afct_pkg::AXI_AW-1:afct_pkg::WORD_LSB] ==
          afct_pkg::CFG_ADDR[afct_pkg::AXI_AW-1:afct_pkg::WORD_LSB]) begin
        if (wr_strb0) begin
          nxt_st.cfg = wr_data;
        end
      end else if (wr_addr[afct_pkg::AXI_AW-1:afct_pkg::WORD_LSB] !=
                   afct_pkg::STAT_ADDR[afct_pkg::AXI_AW-1:afct_pkg::WORD_LSB]) begin
        nxt_st.bresp = afct_pkg::RESP_SLVERR;
      end
    end
    // read channel
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = afct_pkg::RESP_OKAY;
      nxt_st.rdata = '0;
      if (s_axi_araddr[afct_pkg::AXI_AW-1:afct_pkg::WORD_LSB] ==
          afct_pkg::CFG_ADDR[afct_pkg::AXI_AW-1:afct_pkg::WORD_LSB]) begin
        nxt_st.rdata[afct_pkg::CFG_W-1:0] = st_ff.cfg;
      end else if (s_axi_araddr[afct_pkg::AXI_AW-1:afct_pkg::WORD_LSB] ==
                   afct_pkg::STAT_ADDR[afct_pkg::AXI_AW-1:afct_pkg::WORD_LSB]) begin
        nxt_st.rdata[afct_pkg::STAT_W-1:0] = stat;
      end else begin
        nxt_st.rresp = afct_pkg::RESP_SLVERR;
      end
    end
    // one pause request per high-level episode
    if (!fifo_level_reached) begin
      nxt_st.pause_sent = 1'b0;
    end else if (full_duplex && tx_enable && trig_any && !st_ff.pause_sent) begin
      nxt_st.pause_req = 1'b1;
      nxt_st.pause_sent = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.cfg <= afct_pkg::CFG_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  chk_fd_no_jam: assert property (full_duplex |-> !backpressure)
    else $error("back pressure in full duplex");
  chk_txoff_quiet: assert property (!tx_enable |-> !backpressure && !pause_request)
    else $error("flow control active with transmitter off");
  chk_any_preamble: assert property (
    half_ok && fifo_level_reached && trig_any && rx_preamble_valid ##1 half_ok
    |-> backpressure)
    else $error("preamble did not start back pressure");
  chk_mc_trigger: assert property (
    half_ok && fifo_level_reached && !trig_any && st_ff.cfg[afct_pkg::TRIG_MC_BIT] &&
    rx_da_valid && rx_da_multicast ##1 half_ok |-> backpressure)
    else $error("multicast frame did not jam");
  chk_bc_trigger: assert property (
    half_ok && fifo_level_reached && !trig_any && st_ff.cfg[afct_pkg::TRIG_BC_BIT] &&
    rx_da_valid && rx_da_broadcast ##1 half_ok |-> backpressure)
    else $error("broadcast frame did not jam");
  chk_addr_trigger: assert property (
    half_ok && fifo_level_reached && !trig_any && st_ff.cfg[afct_pkg::TRIG_ADDR_BIT] &&
    rx_da_valid && rx_da_addr_match ##1 half_ok |-> backpressure)
    else $error("address-matched frame did not jam");
  chk_no_level_no_jam: assert property (
    !backpressure && !fifo_level_reached |=> !backpressure)
    else $error("back pressure began below the high level");
  chk_pause_cause: assert property (
    pause_request |-> $past(full_duplex && fifo_level_reached && trig_any && tx_enable))
    else $error("pause request without its cause");
  chk_pause_single: assert property (pause_request && fifo_level_reached |=> !pause_request)
    else $error("pause request repeated");
  chk_jam_code0: assert property (
    lnk.start && !lnk.busy && dur_code == '0 && !speed_10mbps
    |-> lnk.load == afct_pkg::afct_cnt_t'(1250))
    else $error("code zero period wrong at 100 Mbps");
  chk_jam_10m_extra: assert property (
    speed_10mbps |-> dur_cyc == BP_CYC_100[dur_code] + afct_pkg::afct_cnt_t'(550))
    else $error("10 Mbps period lacks its extra time");
  chk_reset_cfg: assert property ($past(srst) |-> st_ff.cfg == '0)
    else $error("configuration not cleared by reset");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");

  cov_hd_jam: cover property (half_ok && lnk.start ##1 backpressure);
  cov_fd_pause: cover property (pause_request);
  cov_10m_jam: cover property (speed_10mbps && lnk.start);
  cov_cfg_write: cover property (do_write && st_ff.bresp == afct_pkg::RESP_OKAY);
endmodule
`default_nettype wire

// ===== hw/afct_pkg.sv
// afct_pkg: constants and types of the automatic flow control trigger
package afct_pkg;
  // ****************************************
  // register bus
  // ****************************************
  localparam int AXI_AW = 12;
  localparam int AXI_DW = 32;
  localparam logic [AXI_AW-1:0] CFG_ADDR = 12'h02C;
  localparam logic [AXI_AW-1:0] STAT_ADDR = 12'h040;
  localparam int WORD_LSB = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // field layout
  // ****************************************
  localparam int CFG_W = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
  localparam int TRIG_ANY_BIT = 0;
  localparam int TRIG_ADDR_BIT = 1;
  localparam int TRIG_BC_BIT = 2;
  localparam int TRIG_MC_BIT = 3;
  localparam int TRIG_W = 4;
  localparam int DUR_LSB = 4;
  localparam int DUR_W = 4;
  localparam int DUR_CODES = 16;
  localparam int STAT_BP_BIT = 0;
  localparam int STAT_LVL_BIT = 1;
  localparam int STAT_PSENT_BIT = 2;
  localparam int STAT_FD_BIT = 3;
  localparam int STAT_SPD10_BIT = 4;
  localparam int STAT_W = 5;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int US_NS = 1000;
  localparam int BP_EXTRA_10_NS = 2200;
  localparam int BP_US_100 [DUR_CODES] = '{5, 10, 15, 25, 50, 100, 150, 200,
                                           250, 300, 350, 400, 450, 500, 550, 600};
  localparam int CNT_W = 18;
  typedef logic [CNT_W-1:0] afct_cnt_t;
  typedef afct_cnt_t afct_tab_t [DUR_CODES];
  function automatic afct_cnt_t ns_to_cyc(input int ns);
    return afct_cnt_t'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction
  function automatic afct_tab_t bp_tab_100();
    afct_tab_t t;
    for (int i = 0; i < DUR_CODES; i++) begin
      t[i] = ns_to_cyc(BP_US_100[i] * US_NS);
    end
    return t;
  endfunction
  localparam afct_tab_t BP_CYC_100_DEF = bp_tab_100();
  localparam afct_cnt_t BP_CYC_EXTRA_10_DEF = ns_to_cyc(BP_EXTRA_10_NS);
endpackage

// ===== hw/afct_link_if.sv
// afct_link_if: frame events and timer control between the trigger parts
`timescale 1ns/1ps
`default_nettype none
interface afct_link_if;
  logic preamble;
  logic da_valid;
  logic is_mc;
  logic is_bc;
  logic addr_match;
  logic armed;
  logic [afct_pkg::TRIG_W-1:0] trig;
  logic hit;
  logic start;
  logic abort;
  afct_pkg::afct_cnt_t load;
  logic busy;
  modport ctrl (output preamble, da_valid, is_mc, is_bc, addr_match, armed, trig,
                start, abort, load, input hit, busy);
  modport qual (input preamble, da_valid, is_mc, is_bc, addr_match, armed, trig,
                output hit);
  modport timer (input start, abort, load, output busy);
endinterface
`default_nettype wire

// ===== hw/afct_qual.sv
// afct_qual: decides whether a received frame triggers back pressure
`timescale 1ns/1ps
`default_nettype none
module afct_qual (
  input wire logic sys_clk,
  input wire logic srst,
  afct_link_if.qual lnk
);
  logic sel_hit;
  // ****************************************
  // frame qualification
  // ****************************************
  always_comb begin
    sel_hit = (lnk.trig[afct_pkg::TRIG_MC_BIT] & lnk.is_mc) |
              (lnk.trig[afct_pkg::TRIG_BC_BIT] & lnk.is_bc) |
              (lnk.trig[afct_pkg::TRIG_ADDR_BIT] & lnk.addr_match);
    if (lnk.trig[afct_pkg::TRIG_ANY_BIT]) begin
      lnk.hit = lnk.armed & lnk.preamble;
    end else begin
      lnk.hit = lnk.armed & lnk.da_valid & sel_hit;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  chk_any_overrides: assert property (
    lnk.trig[afct_pkg::TRIG_ANY_BIT] && !lnk.preamble |-> !lnk.hit)
    else $error("selective trigger fired while any-frame trigger set");
  chk_unarmed_quiet: assert property (!lnk.armed |-> !lnk.hit)
    else $error("frame triggered while not armed");
endmodule
`default_nettype wire

// ===== hw/afct_timer.sv
// afct_timer: back-pressure duration timer
`timescale 1ns/1ps
`default_nettype none
module afct_timer (
  input wire logic sys_clk,
  input wire logic srst,
  afct_link_if.timer lnk
);
  typedef struct packed {
    logic busy;
    afct_pkg::afct_cnt_t cnt;
  } afct_tmr_st_t;
  afct_tmr_st_t st_ff;
  afct_tmr_st_t nxt_st;
  // ****************************************
  // countdown
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    if (lnk.abort) begin
      nxt_st.busy = 1'b0;
      nxt_st.cnt = '0;
    end else if (lnk.start) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt = lnk.load - afct_pkg::afct_cnt_t'(1);
    end else if (st_ff.busy) begin
      if (st_ff.cnt == '0) begin
        nxt_st.busy = 1'b0;
      end else begin
        nxt_st.cnt = st_ff.cnt - afct_pkg::afct_cnt_t'(1);
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign lnk.busy = st_ff.busy;
  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  chk_timer_load: assert property (lnk.start && !lnk.abort |=> st_ff.busy)
    else $error("timer did not start");
  chk_timer_end: assert property (st_ff.busy && st_ff.cnt == '0 && !lnk.start |=> !st_ff.busy)
    else $error("timer ran past its period");
endmodule
`default_nettype wire

// ===== dv/afct_station.sv
// afct_station: remote station model that sends frames towards the trigger block
`timescale 1ns/1ps
`default_nettype none
module afct_station #(
  parameter int GAP = 6
) (
  input wire logic sys_clk,
  output logic preamble,
  output logic da_valid,
  output logic da_multicast,
  output logic da_broadcast,
  output logic da_match
);
  // ****************************************
  // frame sequencing
  // ****************************************
  logic tgl_ff;
  logic [2:0] kind_ff;
  initial begin
    preamble = 1'b0;
    da_valid = 1'b0;
    kind_ff = 3'h0;
    tgl_ff = 1'b0;
  end
  always @(posedge sys_clk) begin
    tgl_ff <= ~tgl_ff;
  end
  // decode flags mean nothing outside da_valid, so they wander
  assign da_multicast = da_valid ? kind_ff[0] : tgl_ff;
  assign da_broadcast = da_valid ? kind_ff[1] : ~tgl_ff;
  assign da_match = da_valid ? kind_ff[2] : tgl_ff;
  // kind: bit0 multicast, bit1 broadcast, bit2 own address, none other unicast
  task automatic send_frame(input logic [2:0] kind, input logic with_pre);
    @(posedge sys_clk);
    preamble <= with_pre;
    @(posedge sys_clk);
    preamble <= 1'b0;
    repeat (GAP) @(posedge sys_clk);
    da_valid <= 1'b1;
    kind_ff <= kind;
    @(posedge sys_clk);
    da_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== dv/test_auto_flow_control_trigger.sv
// test_auto_flow_control_trigger: self-checking bench of the flow control trigger
`timescale 1ns/1ps
`default_nettype none
module test_auto_flow_control_trigger;
  logic sys_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic level, fdx, spd10, txen, pre, dav, mc, bc, am, backpressure, pause_request;
  int num_errors, tests_run, jam_cnt, pause_cnt;
  afct_top uut (.sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .fifo_level_reached(level), .full_duplex(fdx),
    .speed_10mbps(spd10), .tx_enable(txen), .rx_preamble_valid(pre), .rx_da_valid(dav),
    .rx_da_multicast(mc), .rx_da_broadcast(bc), .rx_da_addr_match(am),
    .backpressure(backpressure), .pause_request(pause_request));
  afct_station stn (.sys_clk(sys_clk), .preamble(pre), .da_valid(dav), .da_multicast(mc),
    .da_broadcast(bc), .da_match(am));
  // ****************************************
  // clock, counters, watchdog
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (backpressure === 1'b1) jam_cnt++;
    if (pause_request === 1'b1) pause_cnt++;
  end
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic aw_p;
    logic w_p;
    logic aw_s;
    logic w_s;
    logic b_s;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // answers sampled at the falling edge, settled until the next rising edge
    while (aw_p || w_p) begin
      @(negedge sys_clk);
      aw_s = s_axi_awready;
      w_s = s_axi_wready;
      @(posedge sys_clk);
      if (aw_p && aw_s === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && w_s === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    do begin
      @(negedge sys_clk);
      b_s = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk);
    end while (b_s !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_s;
    logic rv_s;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ar_s = s_axi_arready;
      @(posedge sys_clk);
    end while (ar_s !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge sys_clk);
      rv_s = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
    end while (rv_s !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic set_cfg(input logic [7:0] v);
    axi_write(afct_pkg::CFG_ADDR, 32'(v), 4'h1, rsp);
    check("cfg bresp", 32'(afct_pkg::RESP_OKAY), 32'(rsp));
    axi_read(afct_pkg::CFG_ADDR, rd, rsp);
    check("cfg readback", 32'(v), rd);
  endtask
  // jam length in cycles of 4 ns for a duration code
  function automatic int dur(input int code, input int ten);
    int us;
    us = (code < 3) ? 5 * (code + 1) : (code < 6) ? 25 << (code - 3) : 150 + 50 * (code - 6);
    return us * 1000 / 4 + (ten != 0 ? 2200 / 4 : 0);
  endfunction
  task automatic frame_jam(input logic [2:0] kind, input logic with_pre, input int n);
    jam_cnt = 0;
    stn.send_frame(kind, with_pre);
    repeat (n + 30) @(posedge sys_clk);
    check("jam cycles", 32'(n), 32'(jam_cnt));
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    num_errors = 0;
    tests_run = 0;
    jam_cnt = 0;
    pause_cnt = 0;
    srst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {level, fdx, spd10} = 3'h0;
    txen = 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    axi_read(afct_pkg::CFG_ADDR, rd, rsp);
    check("cfg after reset", 32'h0000_0000, rd);
    axi_read(12'h100, rd, rsp);
    check("unmapped rresp", 32'(afct_pkg::RESP_SLVERR), 32'(rsp));
    check("unmapped rdata", 32'h0000_0000, rd);
    axi_write(12'h100, 32'h0000_00FF, 4'hF, rsp);
    check("unmapped bresp", 32'(afct_pkg::RESP_SLVERR), 32'(rsp));
    level <= 1'b1;
    set_cfg(8'h08);
    axi_write(afct_pkg::CFG_ADDR, 32'h0000_00FF, 4'h0, rsp);
    axi_read(afct_pkg::CFG_ADDR, rd, rsp);
    check("cfg masked write", 32'h0000_0008, rd);
    frame_jam(3'h1, 1'b1, dur(0, 0));
    frame_jam(3'h2, 1'b1, 0);
    level <= 1'b0;
    frame_jam(3'h1, 1'b1, 0);
    level <= 1'b1;
    set_cfg(8'h24);
    frame_jam(3'h2, 1'b1, dur(2, 0));
    frame_jam(3'h1, 1'b1, 0);
    spd10 <= 1'b1;
    set_cfg(8'h02);
    frame_jam(3'h4, 1'b1, dur(0, 1));
    frame_jam(3'h0, 1'b1, 0);
    spd10 <= 1'b0;
    set_cfg(8'h01);
    frame_jam(3'h0, 1'b1, dur(0, 0));
    set_cfg(8'h0F);
    frame_jam(3'h1, 1'b0, 0);
    txen <= 1'b0;
    frame_jam(3'h1, 1'b1, 0);
    level <= 1'b0;
    txen <= 1'b1;
    fdx <= 1'b1;
    repeat (5) @(posedge sys_clk);
    pause_cnt = 0;
    level <= 1'b1;
    repeat (20) @(posedge sys_clk);
    check("pause on level", 32'd1, 32'(pause_cnt));
    frame_jam(3'h1, 1'b1, 0);
    check("single pause", 32'd1, 32'(pause_cnt));
    axi_read(afct_pkg::STAT_ADDR, rd, rsp);
    check("status word", 32'h0000_000E, rd);
    level <= 1'b0;
    txen <= 1'b0;
    repeat (5) @(posedge sys_clk);
    level <= 1'b1;
    repeat (20) @(posedge sys_clk);
    check("pause tx off", 32'd1, 32'(pause_cnt));
    txen <= 1'b1;
    repeat (20) @(posedge sys_clk);
    check("pause tx back", 32'd2, 32'(pause_cnt));
    tally_and_finish();
  end
endmodule
`default_nettype wire
